// >>> core/pcs_pkg.sv
// Package: offsets, fields, reset values and types of the command/status bank
package pcs_pkg;

	// Register bus widths
	localparam int ADDR_W   = 8;
	localparam int DATA_W   = 8;
	localparam int MEM_AW   = 7;

	// Register offsets
	localparam logic [7:0] OFS_MEM_ADDR = 8'h0b;
	localparam logic [7:0] OFS_MEM_DATA = 8'h0c;
	localparam logic [7:0] OFS_MEM_STAT = 8'h0e;
	localparam logic [7:0] OFS_CMD      = 8'h10;
	localparam logic [7:0] OFS_MODE     = 8'h12;

	// Command strobe bit positions
	localparam int CMD_CONV_START  = 7;
	localparam int CMD_RESULT_CLR  = 6;
	localparam int CMD_COUNTER_CLR = 5;
	localparam int CMD_CAL_START   = 4;
	localparam int CMD_RELOAD      = 2;
	localparam int CMD_RESET       = 0;

	// Memory read status/control bit positions
	localparam int STAT_BUSY = 3;
	localparam int STAT_READ = 2;

	// Converter mode status bit positions
	localparam int MODE_SINGLE_CELL = 3;
	localparam int MODE_SECOND      = 2;
	localparam int MODE_FIRST_LSB   = 0;

	// Reset values
	localparam logic [6:0] MEM_ADDR_RST = 7'h00;
	localparam logic [7:0] MEM_DATA_RST = 8'h00;
	localparam logic [7:0] MODE_RST     = 8'h00;
	localparam logic [7:0] RDATA_RST    = 8'h00;

	// Cycles the single-cell pin needs through its synchroniser
	localparam logic [1:0] SC_SETTLE    = 2'h2;

	// First output converter modes
	typedef enum logic [1:0] {
		PCS_FIRST_BUCK   = 2'h0,
		PCS_FIRST_AUTO   = 2'h1,
		PCS_FIRST_BOOST  = 2'h2,
		PCS_FIRST_LINEAR = 2'h3
	} pcs_first_mode_t;

	// Memory sequencer states, Gray along the path
	typedef enum logic [1:0] {
		PCS_SEQ_IDLE = 2'b00,
		PCS_SEQ_REQ  = 2'b01,
		PCS_SEQ_STEP = 2'b11
	} pcs_seq_state_t;

endpackage

// >>> core/pcs_mem_if.sv
// Interface: register bank to one-time-memory sequencer
interface pcs_mem_if;
	logic                      start_read;   // Single read request
	logic                      start_reload; // Full defaults sweep
	logic [pcs_pkg::MEM_AW-1:0] read_addr;   // Location for single read
	logic                      busy;         // Sequencer working
	logic [7:0]                rdata;        // Last single-read data

	modport ctrl (
		output start_read,
		output start_reload,
		output read_addr,
		input  busy,
		input  rdata
	);
	modport seq (
		input  start_read,
		input  start_reload,
		input  read_addr,
		output busy,
		output rdata
	);
endinterface

// >>> core/pcs_mem_reader.sv
// Module: one-time-memory read and defaults reload sequencer
module pcs_mem_reader #(
	parameter int RELOAD_WORDS = 128
) (
	// Clock and reset
	input  wire logic              i_clock,
	input  wire logic              i_rst,
	// Register bank side
	pcs_mem_if.seq                 bus,
	// Memory side
	output logic                   o_mem_req,
	output logic [6:0]             o_mem_addr,
	input  wire logic              i_mem_ack,
	input  wire logic [7:0]        i_mem_data,
	// Defaults load stream
	output logic                   o_load_valid,
	output logic [6:0]             o_load_addr,
	output logic [7:0]             o_load_data
);

	localparam logic [6:0] LAST = 7'(RELOAD_WORDS - 1);

	pcs_pkg::pcs_seq_state_t state_r; // Sequencer state
	logic                    sweep_r; // Reload sweep, not single read
	logic                    busy_r;  // Busy flag shown to software
	logic [7:0]              rdata_r; // Single-read result

	assign bus.busy  = busy_r;
	assign bus.rdata = rdata_r;

	////////////////////////////////////////////////////////////////////
	// Sequencer: request held until the memory acknowledges
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			state_r    <= pcs_pkg::PCS_SEQ_IDLE;
			sweep_r    <= 1'b0;
			busy_r     <= 1'b0;
			o_mem_req  <= 1'b0;
			o_mem_addr <= pcs_pkg::MEM_ADDR_RST;
		end else begin
			unique case (state_r)
				pcs_pkg::PCS_SEQ_IDLE: begin
					// Reload wins if both arrive together
					if (bus.start_reload) begin
						state_r    <= pcs_pkg::PCS_SEQ_REQ;
						sweep_r    <= 1'b1;
						busy_r     <= 1'b1;
						o_mem_req  <= 1'b1;
						o_mem_addr <= 7'h00;
					end else if (bus.start_read) begin
						state_r    <= pcs_pkg::PCS_SEQ_REQ;
						sweep_r    <= 1'b0;
						busy_r     <= 1'b1;
						o_mem_req  <= 1'b1;
						o_mem_addr <= bus.read_addr;
					end
				end
				pcs_pkg::PCS_SEQ_REQ: begin
					if (i_mem_ack) begin
						o_mem_req <= 1'b0;
						if (sweep_r && o_mem_addr != LAST) begin
							state_r <= pcs_pkg::PCS_SEQ_STEP;
						end else begin
							state_r <= pcs_pkg::PCS_SEQ_IDLE;
							busy_r  <= 1'b0;
						end
					end
				end
				pcs_pkg::PCS_SEQ_STEP: begin
					// Next location of the sweep
					state_r    <= pcs_pkg::PCS_SEQ_REQ;
					o_mem_req  <= 1'b1;
					o_mem_addr <= o_mem_addr + 7'h01;
				end
				default: begin
					state_r <= pcs_pkg::PCS_SEQ_IDLE;
					busy_r  <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Results: single read to data register, sweep to load stream
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			rdata_r      <= pcs_pkg::MEM_DATA_RST;
			o_load_valid <= 1'b0;
			o_load_addr  <= 7'h00;
			o_load_data  <= 8'h00;
		end else begin
			o_load_valid <= 1'b0;
			if (state_r == pcs_pkg::PCS_SEQ_REQ && i_mem_ack) begin
				if (sweep_r) begin
					o_load_valid <= 1'b1;
					o_load_addr  <= o_mem_addr;
					o_load_data  <= i_mem_data;
				end else begin
					rdata_r <= i_mem_data;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	read_data_a: assert property (@(posedge i_clock) disable iff (i_rst)
		(state_r == pcs_pkg::PCS_SEQ_REQ && i_mem_ack && !sweep_r)
		|=> (rdata_r == $past(i_mem_data) && !busy_r))
		else $error("single read data not captured");

endmodule

// >>> core/pcs_cmd_status.sv
// Module: command strobes, memory read control and converter mode status
module pcs_cmd_status #(
	parameter int RELOAD_WORDS = 128
) (
	// Clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_rst,
	// Register port
	input  wire logic [7:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr_stb,
	input  wire logic        i_rd_stb,
	output logic [7:0]       o_rdata,
	// Conversion control
	output logic             o_conv_start,
	output logic             o_result_load_direct,
	input  wire logic        i_conv_done,
	// Charge counter control
	output logic             o_counter_clear,
	output logic             o_cal_start,
	output logic             o_mode_hold,
	input  wire logic        i_cal_done,
	// Device control
	output logic             o_device_reset,
	output logic             o_defaults_reload,
	// Converter and supply pins, asynchronous
	input  wire logic [1:0]  i_first_mode,
	input  wire logic        i_second_mode,
	input  wire logic        i_single_cell_pin,
	// One-time memory
	output logic             o_mem_req,
	output logic [6:0]       o_mem_addr,
	input  wire logic        i_mem_ack,
	input  wire logic [7:0]  i_mem_data,
	// Defaults load stream
	output logic             o_load_valid,
	output logic [6:0]       o_load_addr,
	output logic [7:0]       o_load_data
);

	////////////////////////////////////////////////////////////////////
	// Declarations

	pcs_mem_if mem ();

	logic       wr_cmd;       // Write to command register
	logic       wr_stat;      // Write to memory status/control
	logic       wr_maddr;     // Write to memory address
	logic       mode_addr;    // Mode register addressed
	logic       read_go;      // Accepted single read
	logic       reload_go;    // Accepted defaults reload
	logic [3:0] pin_s1_r;     // Synchroniser first stage
	logic [3:0] pin_s2_r;     // Synchroniser second stage
	logic [1:0] sc_cnt_r;     // Settle count after reset
	logic       sc_done_r;    // Single-cell level captured
	logic       sc_r;         // Captured single-cell level
	logic [7:0] mode_r;       // Converter mode status
	logic [6:0] maddr_r;      // Memory address register
	logic [7:0] rdata_nxt;    // Read mux

	////////////////////////////////////////////////////////////////////
	// Address decode; reads of reserved bits come back zero

	assign wr_cmd    = i_wr_stb && i_addr == pcs_pkg::OFS_CMD;
	assign wr_stat   = i_wr_stb && i_addr == pcs_pkg::OFS_MEM_STAT;
	assign wr_maddr  = i_wr_stb && i_addr == pcs_pkg::OFS_MEM_ADDR;
	// Address alone freezes the capture, strobe or not
	assign mode_addr = i_addr == pcs_pkg::OFS_MODE;

	// Busy sequencer ignores new starts; no queue to lose track of
	assign read_go   = wr_stat && i_wdata[pcs_pkg::STAT_READ]
		&& !mem.busy;
	assign reload_go = wr_cmd && i_wdata[pcs_pkg::CMD_RELOAD]
		&& !mem.busy;

	assign mem.start_read   = read_go;
	assign mem.start_reload = reload_go;
	assign mem.read_addr    = maddr_r;

	////////////////////////////////////////////////////////////////////
	// Command strobes: one cycle each, zero bits do nothing
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_conv_start      <= 1'b0;
			o_counter_clear   <= 1'b0;
			o_cal_start       <= 1'b0;
			o_device_reset    <= 1'b0;
			o_defaults_reload <= 1'b0;
		end else begin
			o_conv_start    <= wr_cmd
				&& i_wdata[pcs_pkg::CMD_CONV_START];
			o_counter_clear <= wr_cmd
				&& i_wdata[pcs_pkg::CMD_COUNTER_CLR];
			o_cal_start     <= wr_cmd
				&& i_wdata[pcs_pkg::CMD_CAL_START];
			o_device_reset  <= wr_cmd
				&& i_wdata[pcs_pkg::CMD_RESET];
			o_defaults_reload <= reload_go;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Direct-load request: stands until the next conversion ends
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_result_load_direct <= 1'b0;
		end else if (wr_cmd && i_wdata[pcs_pkg::CMD_RESULT_CLR]) begin
			// Set wins over a finishing conversion
			o_result_load_direct <= 1'b1;
		end else if (i_conv_done) begin
			o_result_load_direct <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Mode hold: keeps the converter still during calibration
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_mode_hold <= 1'b0;
		end else if (wr_cmd && i_wdata[pcs_pkg::CMD_CAL_START]) begin
			o_mode_hold <= 1'b1;
		end else if (i_cal_done) begin
			o_mode_hold <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Memory address register, back to default on reload
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			maddr_r <= pcs_pkg::MEM_ADDR_RST;
		end else if (reload_go) begin
			maddr_r <= pcs_pkg::MEM_ADDR_RST;
		end else if (wr_maddr) begin
			maddr_r <= i_wdata[6:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers: converter modes and single-cell detect
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			pin_s1_r <= 4'h0;
			pin_s2_r <= 4'h0;
		end else begin
			pin_s1_r <= {i_single_cell_pin, i_second_mode, i_first_mode};
			pin_s2_r <= pin_s1_r;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Single-cell capture: once, after the synchroniser has filled
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			sc_cnt_r  <= 2'h0;
			sc_done_r <= 1'b0;
			sc_r      <= 1'b0;
		end else if (!sc_done_r) begin
			if (sc_cnt_r == pcs_pkg::SC_SETTLE) begin
				sc_done_r <= 1'b1;
				sc_r      <= pin_s2_r[3];
			end else begin
				sc_cnt_r <= sc_cnt_r + 2'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Mode status: tracks converter mode pins, frozen while addressed.
	// Costs one stale cycle after the address moves away.
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			mode_r <= pcs_pkg::MODE_RST;
		end else if (!mode_addr) begin
			mode_r <= {4'h0, sc_r, pin_s2_r[2], pin_s2_r[1:0]};
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read mux; command register is write-only and reads zero
	always_comb begin
		rdata_nxt = 8'h00;
		unique case (i_addr)
			pcs_pkg::OFS_MEM_ADDR: rdata_nxt = {1'b0, maddr_r};
			pcs_pkg::OFS_MEM_DATA: rdata_nxt = mem.rdata;
			pcs_pkg::OFS_MEM_STAT:
				rdata_nxt[pcs_pkg::STAT_BUSY] = mem.busy;
			pcs_pkg::OFS_MODE:     rdata_nxt = mode_r;
			default:               rdata_nxt = 8'h00;
		endcase
	end

	// Read data stand for the one cycle after the strobe only
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= pcs_pkg::RDATA_RST;
		end else if (i_rd_stb) begin
			o_rdata <= rdata_nxt;
		end else begin
			o_rdata <= pcs_pkg::RDATA_RST;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Memory sequencer
	pcs_mem_reader #(
		.RELOAD_WORDS (RELOAD_WORDS)
	) u_reader (
		.i_clock      (i_clock),
		.i_rst        (i_rst),
		.bus          (mem.seq),
		.o_mem_req    (o_mem_req),
		.o_mem_addr   (o_mem_addr),
		.i_mem_ack    (i_mem_ack),
		.i_mem_data   (i_mem_data),
		.o_load_valid (o_load_valid),
		.o_load_addr  (o_load_addr),
		.o_load_data  (o_load_data)
	);

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);

	read_busy_a: assert property (
		read_go |=> mem.busy && o_mem_req && o_mem_addr == $past(maddr_r))
		else $error("read start did not raise busy");

	// Second cycle may stay high only for a back-to-back start write
	conv_start_a: assert property (
		wr_cmd && i_wdata[pcs_pkg::CMD_CONV_START] |=> o_conv_start
			##1 (!o_conv_start
			|| $past(wr_cmd && i_wdata[pcs_pkg::CMD_CONV_START])))
		else $error("conversion start not a single pulse");

	direct_load_a: assert property (
		o_result_load_direct && !i_conv_done |=> o_result_load_direct)
		else $error("direct load request dropped early");

	counter_clr_a: assert property (
		o_counter_clear |-> $past(wr_cmd && i_wdata[5]))
		else $error("counter clear without command");

	cal_start_a: assert property (
		wr_cmd && i_wdata[4] |=> o_cal_start && o_mode_hold)
		else $error("calibration start missing");

	// A fast memory may answer at once, so only the first cycle is fixed
	reload_a: assert property (
		reload_go |=> o_defaults_reload
			&& maddr_r == pcs_pkg::MEM_ADDR_RST
			&& o_mem_req && o_mem_addr == 7'h00)
		else $error("reload did not restore defaults");

	dev_reset_a: assert property (
		o_device_reset |-> $past(wr_cmd && i_wdata[0]))
		else $error("device reset without command");

	single_cell_a: assert property (
		sc_done_r |=> $stable(sc_r) && sc_done_r)
		else $error("single-cell level changed after capture");

	second_mode_a: assert property (
		!mode_addr |=> mode_r[2] == $past(pin_s2_r[2]))
		else $error("second converter mode not tracked");

	mode_freeze_a: assert property (
		mode_addr |=> $stable(mode_r))
		else $error("mode register changed while addressed");

	mode_hold_a: assert property (
		o_mode_hold && !i_cal_done |=> o_mode_hold)
		else $error("mode hold released before calibration end");

	first_mode_a: assert property (
		!mode_addr |=> mode_r[1:0] == $past(pin_s2_r[1:0]))
		else $error("first converter mode not tracked");

	pulse_only_a: assert property (
		!wr_cmd |=> !o_conv_start && !o_counter_clear && !o_cal_start
			&& !o_device_reset && !o_defaults_reload)
		else $error("command bit kept state");

	////////////////////////////////////////////////////////////////////
	// Read path and the set side of counter clear and device reset.
	// A write must make each strobe; conversion start, counter clear and device
	// reset are also checked not to appear without their write.

	conv_only_a: assert property (
		o_conv_start |-> $past(wr_cmd && i_wdata[pcs_pkg::CMD_CONV_START]))
		else $error("conversion start without command");

	cmd_read_a: assert property (
		i_rd_stb && i_addr == pcs_pkg::OFS_CMD |=> o_rdata == 8'h00)
		else $error("command register did not read zero");

	counter_set_a: assert property (
		wr_cmd && i_wdata[pcs_pkg::CMD_COUNTER_CLR]
		|=> o_counter_clear)
		else $error("counter clear missing");

	reset_set_a: assert property (
		wr_cmd && i_wdata[pcs_pkg::CMD_RESET]
		|=> o_device_reset)
		else $error("device reset request missing");

	busy_read_a: assert property (
		i_rd_stb && i_addr == pcs_pkg::OFS_MEM_STAT
		|=> o_rdata == {4'h0, $past(mem.busy), 3'h0})
		else $error("busy flag not read back");

	// Busy may only fall on the edge that takes a memory answer
	busy_hold_a: assert property (
		mem.busy && !i_mem_ack |=> mem.busy)
		else $error("busy dropped before the memory answered");

	sc_latch_a: assert property (
		!sc_done_r && sc_cnt_r == pcs_pkg::SC_SETTLE
		|=> sc_r == $past(pin_s2_r[3]))
		else $error("single-cell level not captured");

	data_read_a: assert property (
		i_rd_stb && i_addr == pcs_pkg::OFS_MEM_DATA
		|=> o_rdata == $past(mem.rdata))
		else $error("memory data not read back");

	read_cov: cover property (read_go ##[1:20] !mem.busy);
	reload_cov: cover property (reload_go ##[1:300] o_load_valid);
	cal_cov: cover property (o_cal_start ##[1:50] i_cal_done);
	freeze_cov: cover property (mode_addr && i_rd_stb);

endmodule

// >>> dv/testbench.sv
// Testbench: command strobes, memory read control and mode status bank
module testbench;
	timeunit 1ns;
	timeprecision 100ps;

	////////////////////////////////////////////////////////////////////////
	// Stimulus and observation signals
	localparam int NW = 4;         // Short reload sweep keeps the run brief
	logic       i_clock;           // Bench clock, 40 MHz
	logic       i_rst;             // Asynchronous reset, active high
	logic [7:0] i_addr;            // Register address
	logic [7:0] i_wdata;           // Write data
	logic       i_wr_stb;          // Write strobe
	logic       i_rd_stb;          // Read strobe
	logic [7:0] o_rdata;           // Read data
	logic       o_conv_start, o_result_load_direct, i_conv_done;
	logic       o_counter_clear, o_cal_start, o_mode_hold, i_cal_done;
	logic       o_device_reset, o_defaults_reload;
	logic [1:0] i_first_mode;      // First converter mode pins
	logic       i_second_mode;     // Second converter mode pin
	logic       i_single_cell_pin; // Single-cell supply sense
	logic       o_mem_req, i_mem_ack, o_load_valid;
	logic [6:0] o_mem_addr, o_load_addr;
	logic [7:0] i_mem_data, o_load_data;
	logic [3:0] ack_cnt;           // Memory answer delay
	int         load_cnt;          // Defaults words seen
	int         num_errors;        // Mismatches
	int         checked;           // Comparisons made
	logic [7:0] rd;                // Last read value

	pcs_cmd_status #(.RELOAD_WORDS(NW)) i_dut (
		.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb),
		.o_rdata(o_rdata), .o_conv_start(o_conv_start),
		.o_result_load_direct(o_result_load_direct),
		.i_conv_done(i_conv_done), .o_counter_clear(o_counter_clear),
		.o_cal_start(o_cal_start), .o_mode_hold(o_mode_hold),
		.i_cal_done(i_cal_done), .o_device_reset(o_device_reset),
		.o_defaults_reload(o_defaults_reload),
		.i_first_mode(i_first_mode), .i_second_mode(i_second_mode),
		.i_single_cell_pin(i_single_cell_pin), .o_mem_req(o_mem_req),
		.o_mem_addr(o_mem_addr), .i_mem_ack(i_mem_ack),
		.i_mem_data(i_mem_data), .o_load_valid(o_load_valid),
		.o_load_addr(o_load_addr), .o_load_data(o_load_data)
	);

	////////////////////////////////////////////////////////////////////////
	// Clock
	always #12.5 i_clock = ~i_clock;

	// Memory content, distinct per location
	function automatic logic [7:0] mem_word(input logic [6:0] a);
		return {1'b1, a} ^ 8'h3c;
	endfunction

	// Slow memory: answers six cycles after a request appears
	always @(posedge i_clock) begin
		if (o_mem_req === 1'b1 && i_mem_ack === 1'b0) begin
			ack_cnt <= ack_cnt + 4'h1;
			if (ack_cnt == 4'h5) begin
				i_mem_ack  <= 1'b1;
				i_mem_data <= mem_word(o_mem_addr);
			end
		end else begin
			ack_cnt   <= 4'h0;
			i_mem_ack <= 1'b0;
		end
	end

	// Defaults stream: each word in order, carrying the memory data
	always @(posedge i_clock) begin
		if (o_load_valid === 1'b1) begin
			check("load_addr", {1'b0, o_load_addr}, 8'(load_cnt));
			check("load_data", o_load_data, mem_word(7'(load_cnt)));
			load_cnt++;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Access tasks
	task automatic check(input string nm, input logic [7:0] seen,
		input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One-cycle write; returns just after the edge that takes it
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clock);
		i_wr_stb <= 1'b1;
		i_addr   <= a;
		i_wdata  <= d;
		@(posedge i_clock);
		i_wr_stb <= 1'b0;
		i_addr   <= 8'h00;
		#1;
	endtask

	// One-cycle read; data taken in the cycle after the strobe
	task automatic rdr(input logic [7:0] a);
		@(posedge i_clock);
		i_rd_stb <= 1'b1;
		i_addr   <= a;
		@(posedge i_clock);
		i_rd_stb <= 1'b0;
		i_addr   <= 8'h00;
		#1;
		rd = o_rdata;
	endtask

	// Poll busy under a bound
	task automatic wait_idle();
		for (int i = 0; i < 100; i++) begin
			rdr(pcs_pkg::OFS_MEM_STAT);
			if (rd[pcs_pkg::STAT_BUSY] === 1'b0)
				break;
		end
		check("busy_end", rd, 8'h00);
	endtask

	// Pins settle, then mode register compared
	task automatic mode_is(input logic [7:0] exp);
		repeat (6) @(posedge i_clock);
		rdr(pcs_pkg::OFS_MODE);
		check("mode", rd, exp);
	endtask

	task automatic end_of_test();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Watchdog: 20000 cycles, far beyond the few hundred cycles the tests need
	initial begin
		#(25 * 20000);
		num_errors++;
		end_of_test();
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		int bits [4];
		logic [3:0] pul;
		bits = '{7, 5, 4, 0};
		i_clock = 1'b0; i_rst = 1'b1; i_addr = 8'h00; i_wdata = 8'h00;
		i_wr_stb = 1'b0; i_rd_stb = 1'b0; i_conv_done = 1'b0;
		i_cal_done = 1'b0; i_first_mode = 2'h2; i_second_mode = 1'b1;
		i_single_cell_pin = 1'b1; i_mem_ack = 1'b0; i_mem_data = 8'h00;
		ack_cnt = 4'h0; load_cnt = 0; num_errors = 0; checked = 0;
		repeat (5) @(posedge i_clock);
		i_rst <= 1'b0;
		// Map: write-only, unmapped and idle status read zero
		mode_is(8'h0e);
		rdr(pcs_pkg::OFS_CMD);   check("cmd_rd", rd, 8'h00);
		rdr(8'h20);              check("unmapped", rd, 8'h00);
		rdr(pcs_pkg::OFS_MEM_STAT); check("stat_rst", rd, 8'h00);
		// Every mode code; single-cell pin drop must not show
		for (int m = 0; m < 4; m++) begin
			@(posedge i_clock);
			i_first_mode  <= 2'(m);
			i_second_mode <= m[0];
			i_single_cell_pin <= 1'b0;
			mode_is({5'h01, m[0], 2'(m)});
		end
		// Freeze while addressed, then catch up once released
		@(posedge i_clock); i_addr <= pcs_pkg::OFS_MODE;
		repeat (2) @(posedge i_clock);
		i_first_mode <= 2'h1; i_second_mode <= 1'b0;
		repeat (6) @(posedge i_clock);
		rdr(pcs_pkg::OFS_MODE); check("frozen", rd, 8'h0f);
		mode_is(8'h09);
		// Command strobes: one-cycle pulse, only the written bit
		foreach (bits[k]) begin
			wr(pcs_pkg::OFS_CMD, 8'h01 << bits[k]);
			pul = {o_conv_start, o_counter_clear, o_cal_start, o_device_reset};
			check("pulse", {4'h0, pul}, 8'h08 >> k);
			@(posedge i_clock); #1;
			pul = {o_conv_start, o_counter_clear, o_cal_start, o_device_reset};
			check("pulse_end", {4'h0, pul}, 8'h00);
		end
		// Calibration hold stands until done
		check("hold", {7'h0, o_mode_hold}, 8'h01);
		wr(pcs_pkg::OFS_CMD, 8'h00);
		pul = {o_conv_start, o_counter_clear, o_cal_start, o_device_reset};
		check("zero_wr", {3'h0, pul, o_defaults_reload}, 8'h00);
		check("hold_kept", {7'h0, o_mode_hold}, 8'h01);
		@(posedge i_clock); i_cal_done <= 1'b1;
		@(posedge i_clock); i_cal_done <= 1'b0; #1;
		check("hold_end", {7'h0, o_mode_hold}, 8'h00);
		// Mode after calibration, as read when unloading the counters
		mode_is(8'h09);
		// Direct result load stands until a conversion finishes
		wr(pcs_pkg::OFS_CMD, 8'h40);
		check("direct", {7'h0, o_result_load_direct}, 8'h01);
		repeat (4) @(posedge i_clock); #1;
		check("direct_kept", {7'h0, o_result_load_direct}, 8'h01);
		@(posedge i_clock); i_conv_done <= 1'b1;
		@(posedge i_clock); i_conv_done <= 1'b0; #1;
		check("direct_end", {7'h0, o_result_load_direct}, 8'h00);
		// Single memory read at a programmed location
		wr(pcs_pkg::OFS_MEM_ADDR, 8'h55);
		rdr(pcs_pkg::OFS_MEM_ADDR); check("mem_addr", rd, 8'h55);
		wr(pcs_pkg::OFS_MEM_STAT, 8'h04);
		check("req", {o_mem_req, o_mem_addr}, 8'hd5);
		rdr(pcs_pkg::OFS_MEM_STAT); check("busy", rd, 8'h08);
		wait_idle();
		rdr(pcs_pkg::OFS_MEM_DATA); check("mem_data", rd, mem_word(7'h55));
		// Defaults reload sweeps every word and resets the address
		wr(pcs_pkg::OFS_CMD, 8'h04);
		check("reload", {7'h0, o_defaults_reload}, 8'h01);
		wait_idle();
		check("load_count", 8'(load_cnt), 8'(NW));
		rdr(pcs_pkg::OFS_MEM_ADDR); check("addr_rst", rd, 8'h00);
		// Second reset: single-cell bit taken again, pin now low
		@(posedge i_clock); i_rst <= 1'b1;
		repeat (5) @(posedge i_clock);
		i_rst <= 1'b0;
		mode_is(8'h01);
		end_of_test();
	end
endmodule
